// [logic/nvmem_pkg.sv]
// Shared constants and state types of the serial byte memory slave.
package nvmem_pkg;
    localparam int          ADDR_W        = 15;
    localparam int          MEM_DEPTH     = 32768;
    localparam int          SYNC_W        = 6;
    localparam logic [7:0]  ID_WR_CODE    = 8'hF8;
    localparam logic [7:0]  ID_RD_CODE    = 8'hF9;
    localparam logic [3:0]  BYTE_BITS     = 4'h8;
    localparam logic [3:0]  LAST_TX_BIT   = 4'h7;
    localparam logic [1:0]  ID_LAST_IDX   = 2'h2;
    localparam logic [14:0] ADDR_RESET    = 15'h0000;
    localparam logic [14:0] ADDR_LAST     = 15'h7FFF;
    localparam logic [5:0]  SYNC_RESET    = 6'h01;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_RX     = 3'b001,
        ST_RX_ACK = 3'b010,
        ST_TX     = 3'b011,
        ST_TX_ACK = 3'b100
    } state_e;

    typedef enum logic [2:0] {
        PH_DEV     = 3'b000,
        PH_ID_DEV  = 3'b001,
        PH_ADDR_HI = 3'b010,
        PH_ADDR_LO = 3'b011,
        PH_DATA    = 3'b100,
        PH_RD_MEM  = 3'b101,
        PH_RD_ID   = 3'b110,
        PH_ID_DONE = 3'b111
    } phase_e;
endpackage

// [logic/nvmem_if.sv]
// Interfaces between the line monitor, the byte array and the engine.
interface line_evt_if;
    logic       scl_rise;
    logic       scl_fall;
    logic       start;
    logic       stop;
    logic       sda;
    logic       wp;
    logic [2:0] strap;
    modport mon (output scl_rise, scl_fall, start, stop, sda, wp, strap);
    modport eng (input  scl_rise, scl_fall, start, stop, sda, wp, strap);
endinterface

interface mem_port_if;
    logic        we;
    logic [14:0] waddr;
    logic [7:0]  wdata;
    logic [14:0] raddr;
    logic [7:0]  rdata;
    modport ctrl  (output we, waddr, wdata, raddr, input  rdata);
    modport array (input  we, waddr, wdata, raddr, output rdata);
endinterface

// [logic/line_monitor.sv]
// Pin synchroniser and start, stop and clock edge detector.
module line_monitor (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic       wp_i,
    input  wire logic [2:0] strap_i,
    line_evt_if.mon         ev
);
    import nvmem_pkg::*;

    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    logic              prev_scl;
    logic              prev_sda;

    // Bit 0 is the clock line, bit 1 the data line; both idle high.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_a   <= SYNC_RESET | 6'h02;
            sync_b   <= SYNC_RESET | 6'h02;
            prev_scl <= 1'b1;
            prev_sda <= 1'b1;
        end else begin
            sync_a   <= {strap_i, wp_i, sda_i, scl_i};
            sync_b   <= sync_a;
            prev_scl <= sync_b[0];
            prev_sda <= sync_b[1];
        end
    end

    assign ev.scl_rise = sync_b[0] & ~prev_scl;
    assign ev.scl_fall = ~sync_b[0] & prev_scl;
    assign ev.start    = sync_b[0] & prev_scl & prev_sda & ~sync_b[1];
    assign ev.stop     = sync_b[0] & prev_scl & ~prev_sda & sync_b[1];
    assign ev.sda      = sync_b[1];
    assign ev.wp       = sync_b[2];
    assign ev.strap    = sync_b[5:3];
endmodule

// [logic/byte_array.sv]
// Byte-wide storage array with one write port and a registered read port.
module byte_array (
    input  wire logic clk_i,
    mem_port_if.array mp
);
    import nvmem_pkg::*;

    logic [7:0] mem [0:MEM_DEPTH-1];

    always_ff @(posedge clk_i) begin
        if (mp.we) begin
            mem[mp.waddr] <= mp.wdata;
        end
        mp.rdata <= mem[mp.raddr];
    end
endmodule

// [logic/i2c_nonvolatile_byte_memory_slave.sv]
// Two-wire slave engine of the 32K by 8 nonvolatile byte memory.
// Function
// - Last bit of the device address word picks write (0) or read (1).
// - Wrong type code or select bits returns to standby with no acknowledge.
// - Matching device address word is acknowledged low on the ninth clock.
// - Two memory address bytes follow, high first, each acknowledged low.
// - After addressing, data moves in bytes, each followed by an acknowledge.
// - Write: device takes eight bits then acknowledges before the next byte.
// - Read: device shifts eight bits, then releases data to sample master ack.
// - No programming wait; a new address word is accepted right after stop.
// - While write lock is high, no array location changes.
// - Reads work normally whatever the write lock level.
// - Consecutive write bytes go to following addresses, wrapping to zero.
// - Each write byte is committed when its acknowledge completes.
// - Read without address phase returns last accessed address plus one.
// - Address counter wraps to zero; reset loads it with ADDR_RESET, which is zero.
// - Random read: write address phase, repeated start, read address word.
// - Each low master acknowledge during a read sends the next byte, wrapping.
// - Identification read via reserved F8H, address word, then F9H, three bytes.
// - Acknowledge after third identification byte restarts from the first.
// - Data is sampled on rising clock edges and changed on falling edges.
// - Select bits follow the type code in order 2, 1, 0, compared bitwise.
// - Stop before acknowledge aborts to standby; line released after a NACK.
module i2c_nonvolatile_byte_memory_slave #(
    // Arbitrary device type code value.
    parameter logic [3:0]  DEVICE_TYPE_CODE = 4'h5,
    // Arbitrary identification byte values, first byte in the top bits.
    parameter logic [23:0] ID_BYTES         = 24'h123456
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_n_o,
    input  wire logic chip_select_strap_bit2_i,
    input  wire logic chip_select_strap_bit1_i,
    input  wire logic chip_select_strap_bit0_i,
    input  wire logic write_lock_input_i
);
    import nvmem_pkg::*;

    line_evt_if ev ();
    mem_port_if mem ();

    state_e              state;
    state_e              next_state;
    phase_e              phase;
    phase_e              next_phase;
    logic [3:0]          cnt;
    logic [3:0]          next_cnt;
    logic [7:0]          shreg;
    logic [7:0]          next_shreg;
    logic                release_sda;
    logic                next_release;
    logic [ADDR_W-1:0]   cur_addr;
    logic [ADDR_W-1:0]   next_addr;
    logic [7:0]          addr_hi;
    logic [7:0]          next_addr_hi;
    logic                wr_pend;
    logic                next_wr_pend;
    logic                id_armed;
    logic                next_id_armed;
    logic [1:0]          id_idx;
    logic [1:0]          next_id_idx;
    logic                ack_seen;
    logic                next_ack_seen;
    logic                we;
    logic                next_we;
    logic [ADDR_W-1:0]   waddr;
    logic [ADDR_W-1:0]   next_waddr;
    logic [7:0]          wdata;
    logic [7:0]          next_wdata;
    logic                do_load;
    logic                dev_match;
    logic [7:0]          id_byte;
    logic [7:0]          tx_byte;

    line_monitor u_mon (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .scl_i   (scl_i),
        .sda_i   (sda_i),
        .wp_i    (write_lock_input_i),
        .strap_i ({chip_select_strap_bit2_i, chip_select_strap_bit1_i,
                   chip_select_strap_bit0_i}),
        .ev      (ev)
    );

    byte_array u_mem (
        .clk_i (clk_i),
        .mp    (mem)
    );

    assign mem.we    = we;
    assign mem.waddr = waddr;
    assign mem.wdata = wdata;
    // Reads are never gated by the write lock.
    assign mem.raddr = cur_addr;

    assign dev_match = (shreg[7:4] == DEVICE_TYPE_CODE) &&
                       (shreg[3:1] == ev.strap);

    always_comb begin
        case (id_idx)
            2'h0:    id_byte = ID_BYTES[23:16];
            2'h1:    id_byte = ID_BYTES[15:8];
            default: id_byte = ID_BYTES[7:0];
        endcase
        tx_byte = (phase == PH_RD_ID) ? id_byte : mem.rdata;
    end

    always_comb begin
        next_state    = state;
        next_phase    = phase;
        next_cnt      = cnt;
        next_shreg    = shreg;
        next_release  = release_sda;
        next_addr     = cur_addr;
        next_addr_hi  = addr_hi;
        next_wr_pend  = wr_pend;
        next_id_armed = id_armed;
        next_id_idx   = id_idx;
        next_ack_seen = ack_seen;
        next_we       = 1'b0;
        next_waddr    = waddr;
        next_wdata    = wdata;
        do_load       = 1'b0;
        if (ev.stop) begin
            // The engine is idle at once, so the next word needs no wait.
            next_state    = ST_IDLE;
            next_release  = 1'b1;
            next_wr_pend  = 1'b0;
            next_id_armed = 1'b0;
        end else if (ev.start) begin
            next_state   = ST_RX;
            next_phase   = PH_DEV;
            next_cnt     = 4'h0;
            next_release = 1'b1;
            next_wr_pend = 1'b0;
        end else begin
            case (state)
                ST_RX: begin
                    if (ev.scl_rise && cnt != BYTE_BITS) begin
                        next_shreg = {shreg[6:0], ev.sda};
                        next_cnt   = cnt + 4'h1;
                    end else if (ev.scl_fall && cnt == BYTE_BITS) begin
                        next_state   = ST_RX_ACK;
                        next_release = 1'b0;
                        case (phase)
                            PH_DEV: begin
                                next_id_armed = 1'b0;
                                if (shreg == ID_WR_CODE) begin
                                    next_phase = PH_ID_DEV;
                                end else if (shreg == ID_RD_CODE &&
                                             id_armed) begin
                                    next_phase  = PH_RD_ID;
                                    next_id_idx = 2'h0;
                                end else if (dev_match) begin
                                    next_phase = shreg[0] ? PH_RD_MEM
                                                          : PH_ADDR_HI;
                                end else begin
                                    next_state   = ST_IDLE;
                                    next_release = 1'b1;
                                end
                            end
                            PH_ID_DEV: begin
                                // The direction bit is ignored here.
                                if (dev_match) begin
                                    next_id_armed = 1'b1;
                                    next_phase    = PH_ID_DONE;
                                end else begin
                                    next_state   = ST_IDLE;
                                    next_release = 1'b1;
                                end
                            end
                            PH_ADDR_HI: begin
                                next_addr_hi = shreg;
                                next_phase   = PH_ADDR_LO;
                            end
                            PH_ADDR_LO: begin
                                // The top bit of the high byte is dropped.
                                next_addr  = {addr_hi[6:0], shreg};
                                next_phase = PH_DATA;
                            end
                            PH_DATA: begin
                                next_wr_pend = 1'b1;
                            end
                            default: begin
                                next_state   = ST_IDLE;
                                next_release = 1'b1;
                            end
                        endcase
                    end
                end
                ST_RX_ACK: begin
                    if (ev.scl_fall) begin
                        next_release = 1'b1;
                        next_cnt     = 4'h0;
                        next_state   = ST_RX;
                        if (wr_pend) begin
                            next_we      = ~ev.wp;
                            next_waddr   = cur_addr;
                            next_wdata   = shreg;
                            next_addr    = cur_addr + 15'h0001;
                            next_wr_pend = 1'b0;
                        end
                        case (phase)
                            PH_RD_MEM: do_load = 1'b1;
                            PH_RD_ID:  do_load = 1'b1;
                            PH_ID_DONE: next_state = ST_IDLE;
                            default:    next_state = ST_RX;
                        endcase
                    end
                end
                ST_TX: begin
                    if (ev.scl_fall) begin
                        if (cnt == LAST_TX_BIT) begin
                            next_release = 1'b1;
                            next_state   = ST_TX_ACK;
                        end else begin
                            next_shreg   = {shreg[6:0], 1'b0};
                            next_release = shreg[6];
                            next_cnt     = cnt + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (ev.scl_rise) begin
                        next_ack_seen = ~ev.sda;
                    end else if (ev.scl_fall) begin
                        if (ack_seen) begin
                            do_load = 1'b1;
                        end else begin
                            next_state   = ST_IDLE;
                            next_release = 1'b1;
                        end
                    end
                end
                default: begin
                    next_state   = ST_IDLE;
                    next_release = 1'b1;
                end
            endcase
        end
        if (do_load) begin
            next_state   = ST_TX;
            next_shreg   = tx_byte;
            next_release = tx_byte[7];
            next_cnt     = 4'h0;
            if (phase == PH_RD_ID) begin
                next_id_idx = (id_idx == ID_LAST_IDX) ? 2'h0
                                                     : id_idx + 2'h1;
            end else begin
                next_addr = cur_addr + 15'h0001;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state       <= ST_IDLE;
            phase       <= PH_DEV;
            cnt         <= 4'h0;
            shreg       <= 8'h00;
            release_sda <= 1'b1;
            cur_addr    <= ADDR_RESET;
            addr_hi     <= 8'h00;
            wr_pend     <= 1'b0;
            id_armed    <= 1'b0;
            id_idx      <= 2'h0;
            ack_seen    <= 1'b0;
            we          <= 1'b0;
            waddr       <= ADDR_RESET;
            wdata       <= 8'h00;
            sda_o       <= 1'b0;
            sda_oe_n_o  <= 1'b1;
        end else begin
            state       <= next_state;
            phase       <= next_phase;
            cnt         <= next_cnt;
            shreg       <= next_shreg;
            release_sda <= next_release;
            cur_addr    <= next_addr;
            addr_hi     <= next_addr_hi;
            wr_pend     <= next_wr_pend;
            id_armed    <= next_id_armed;
            id_idx      <= next_id_idx;
            ack_seen    <= next_ack_seen;
            we          <= next_we;
            waddr       <= next_waddr;
            wdata       <= next_wdata;
            sda_o       <= 1'b0;
            sda_oe_n_o  <= next_release;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_mismatch_no_ack: assert property (
        (state == ST_RX && ev.scl_fall && cnt == BYTE_BITS &&
         phase == PH_DEV && !dev_match && shreg != ID_WR_CODE &&
         shreg != ID_RD_CODE && !ev.start && !ev.stop)
        |=> (state == ST_IDLE && sda_oe_n_o) [*2])
        else $error("mismatched address word was acknowledged");
    a_dev_ack_low: assert property (
        (state == ST_RX && ev.scl_fall && cnt == BYTE_BITS &&
         phase == PH_DEV && dev_match && !ev.start && !ev.stop)
        |=> !sda_oe_n_o && state == ST_RX_ACK)
        else $error("matching address word not acknowledged");
    a_addr_byte_ack: assert property (
        (state == ST_RX && ev.scl_fall && cnt == BYTE_BITS &&
         (phase == PH_ADDR_HI || phase == PH_ADDR_LO || phase == PH_DATA)
         && !ev.start && !ev.stop)
        |=> !sda_oe_n_o)
        else $error("address or data byte not acknowledged");
    a_tx_release: assert property (
        (state == ST_TX && ev.scl_fall && cnt == LAST_TX_BIT &&
         !ev.start && !ev.stop)
        |=> sda_oe_n_o && state == ST_TX_ACK)
        else $error("line not released for master acknowledge");
    a_lock_no_write: assert property (
        (state == ST_RX_ACK && ev.scl_fall && ev.wp) |=> !mem.we)
        else $error("array written while locked");
    a_commit_on_ack: assert property (
        (state == ST_RX_ACK && ev.scl_fall && wr_pend && !ev.wp &&
         !ev.start && !ev.stop)
        |=> mem.we && mem.waddr == $past(cur_addr) &&
            cur_addr == $past(cur_addr) + 15'h0001)
        else $error("write byte not committed after acknowledge");
    a_addr_wrap: assert property (
        (do_load && phase == PH_RD_MEM && cur_addr == ADDR_LAST)
        |=> cur_addr == ADDR_RESET)
        else $error("address counter did not wrap");
    a_id_restart: assert property (
        (do_load && phase == PH_RD_ID && id_idx == ID_LAST_IDX)
        |=> id_idx == 2'h0 && state == ST_TX)
        else $error("identification read did not restart");
    a_fall_change: assert property (
        $fell(sda_oe_n_o) |-> $past(ev.scl_fall))
        else $error("data line driven outside a falling clock edge");
    a_stop_idle: assert property (
        ev.stop |=> state == ST_IDLE && sda_oe_n_o)
        else $error("stop did not return to standby");
    a_start_decode: assert property (
        (ev.start && !ev.stop) |=> state == ST_RX && phase == PH_DEV &&
                                   cnt == 4'h0)
        else $error("start did not begin a new address word");

    c_write_commit: cover property (mem.we);
    c_seq_read: cover property (state == ST_TX_ACK && ev.scl_fall &&
                                ack_seen && phase == PH_RD_MEM);
    c_id_read: cover property (do_load && phase == PH_RD_ID &&
                               id_idx == ID_LAST_IDX);
    c_nack_end: cover property (state == ST_TX_ACK && ev.scl_fall &&
                                !ack_seen);
endmodule

// [verification/i2c_master_model.sv]
// Behavioural two-wire bus master that drives the serial clock and data.
module i2c_master_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    // Each phase lasts 12 clocks, well above the engine's 3 clock delay from a pin change to its line output.
    task automatic hp;
        repeat (12) @(posedge clk_i);
        #1;
    endtask

    // Also serves as a repeated start, since it begins with the clock low.
    task automatic start;
        sda_low_o = 1'b0;
        hp;
        scl_o = 1'b1;
        hp;
        sda_low_o = 1'b1;
        hp;
        scl_o = 1'b0;
        hp;
    endtask

    task automatic stop;
        sda_low_o = 1'b1;
        hp;
        scl_o = 1'b1;
        hp;
        sda_low_o = 1'b0;
        hp;
    endtask

    // Data changes only while the clock is low and is sampled before the fall.
    task automatic bit_x(input logic b, output logic s);
        sda_low_o = !b;
        hp;
        scl_o = 1'b1;
        hp;
        s = sda_i;
        scl_o = 1'b0;
        hp;
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], s);
        end
        bit_x(1'b1, ack_n);
    endtask

    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, s);
            d[i] = s;
        end
        bit_x(nack, s);
    endtask
endmodule

// [verification/i2c_nonvolatile_byte_memory_slave_tb.sv]
// Self-checking testbench of the serial byte memory slave engine.
module i2c_nonvolatile_byte_memory_slave_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // Arbitrary type code and identification values.
    localparam logic [3:0]  TYPE = 4'h6;
    localparam logic [23:0] IDB  = 24'h3C5A96;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        scl;
    logic        sda_low;
    logic        sda;
    logic        sda_o;
    logic        sda_oe_n;
    logic [2:0]  strap = 3'b101;
    logic        wp = 1'b0;
    logic [15:0] lfsr = 16'h001F;
    logic [7:0]  d[3];
    logic [7:0]  r;
    logic [14:0] a;
    logic        k;
    int          error_cnt = 0;
    int          comparisons = 0;

    always #5 clk = ~clk;
    // Open-drain line with a pull-up; the device value counts only when enabled.
    assign sda = sda_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_o);

    i2c_nonvolatile_byte_memory_slave #(
        .DEVICE_TYPE_CODE (TYPE),
        .ID_BYTES         (IDB)
    ) i2c_nonvolatile_byte_memory_slave_inst (
        .clk_i                    (clk),
        .rst_i                    (rst),
        .scl_i                    (scl),
        .sda_i                    (sda),
        .sda_o                    (sda_o),
        .sda_oe_n_o               (sda_oe_n),
        .chip_select_strap_bit2_i (strap[2]),
        .chip_select_strap_bit1_i (strap[1]),
        .chip_select_strap_bit0_i (strap[0]),
        .write_lock_input_i       (wp)
    );

    i2c_master_model i2c_master_model_inst (
        .clk_i     (clk),
        .sda_i     (sda),
        .scl_o     (scl),
        .sda_low_o (sda_low)
    );

    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction

    function automatic logic [7:0] dev(input logic rw);
        return {TYPE, strap, rw};
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic addr_ph(input logic [14:0] ad);
        i2c_master_model_inst.start();
        i2c_master_model_inst.wr_byte(dev(1'b0), k);
        chk({7'h00, k}, 8'h00);
        i2c_master_model_inst.wr_byte({1'b0, ad[14:8]}, k);
        chk({7'h00, k}, 8'h00);
        i2c_master_model_inst.wr_byte(ad[7:0], k);
        chk({7'h00, k}, 8'h00);
    endtask

    task automatic rd_start;
        i2c_master_model_inst.start();
        i2c_master_model_inst.wr_byte(dev(1'b1), k);
        chk({7'h00, k}, 8'h00);
    endtask

    task automatic rd_one(input logic [7:0] exp);
        i2c_master_model_inst.rd_byte(1'b1, r);
        chk(r, exp);
        i2c_master_model_inst.stop();
    endtask

    initial begin
        repeat (80000) @(posedge clk);
        error_cnt++;
        test_done;
    end

    initial begin
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (5) @(posedge clk);
        // Wrong select bit in each position, then wrong type code.
        for (int i = 0; i < 4; i++) begin
            i2c_master_model_inst.start();
            i2c_master_model_inst.wr_byte(i < 3 ?
                {TYPE, strap ^ (3'b001 << i), 1'b0} : {~TYPE, strap, 1'b0}, k);
            chk({7'h00, k}, 8'h01);
            i2c_master_model_inst.stop();
        end
        // Page write across the top address.
        addr_ph(15'h7FFE);
        for (int j = 0; j < 3; j++) begin
            d[j] = rnd();
            i2c_master_model_inst.wr_byte(d[j], k);
            chk({7'h00, k}, 8'h00);
        end
        i2c_master_model_inst.stop();
        // Sequential read back with the lock raised.
        wp = 1'b1;
        addr_ph(15'h7FFE);
        rd_start;
        for (int j = 0; j < 3; j++) begin
            i2c_master_model_inst.rd_byte(j == 2, r);
            chk(r, d[j]);
        end
        i2c_master_model_inst.stop();
        // Locked write is acknowledged but leaves the array alone.
        addr_ph(15'h7FFF);
        i2c_master_model_inst.wr_byte(~d[1], k);
        chk({7'h00, k}, 8'h00);
        i2c_master_model_inst.stop();
        wp = 1'b0;
        rd_start;
        rd_one(d[2]);
        addr_ph(15'h7FFF);
        rd_start;
        rd_one(d[1]);
        // A stop inside the low address byte leaves the counter alone.
        i2c_master_model_inst.start();
        i2c_master_model_inst.wr_byte(dev(1'b0), k);
        i2c_master_model_inst.wr_byte(8'h12, k);
        for (int j = 0; j < 4; j++) begin
            i2c_master_model_inst.bit_x(1'b0, k);
        end
        i2c_master_model_inst.stop();
        rd_start;
        rd_one(d[2]);
        // A new strap setting, which the later address words follow.
        strap = 3'(rnd());
        // Random single-byte writes and random reads.
        for (int n = 0; n < 4; n++) begin
            a = 15'({rnd(), rnd()});
            d[0] = rnd();
            addr_ph(a);
            i2c_master_model_inst.wr_byte(d[0], k);
            i2c_master_model_inst.stop();
            addr_ph(a);
            rd_start;
            rd_one(d[0]);
        end
        // Identification read, acknowledging the third byte once.
        i2c_master_model_inst.start();
        i2c_master_model_inst.wr_byte(8'hF8, k);
        chk({7'h00, k}, 8'h00);
        i2c_master_model_inst.wr_byte(dev(rnd() > 8'h7F), k);
        chk({7'h00, k}, 8'h00);
        i2c_master_model_inst.start();
        i2c_master_model_inst.wr_byte(8'hF9, k);
        chk({7'h00, k}, 8'h00);
        for (int j = 0; j < 4; j++) begin
            i2c_master_model_inst.rd_byte(j == 3, r);
            chk(r, IDB[23 - 8 * (j % 3) -: 8]);
        end
        i2c_master_model_inst.stop();
        // The read code alone, without the arming sequence, is refused.
        i2c_master_model_inst.start();
        i2c_master_model_inst.wr_byte(8'hF9, k);
        chk({7'h00, k}, 8'h01);
        i2c_master_model_inst.stop();
        test_done;
    end
endmodule
